// ---- mpcr_cell_mask.v ----
// decodes the series-cell count into a per-cell enable mask
`include "mpcr_defines.vh"
`default_nettype none
module mpcr_cell_mask #(
    parameter CELLS = 6
) (
    // count code
    input wire [1:0] cell_code,
    // one bit per cell, cell 1 in bit 0
    output wire [CELLS-1:0] cell_enable
);
    // number of cells in use
    reg [3:0] used;
    always @* begin
        case (cell_code)
            `MPCR_CN_SIX: used = 4'h6;
            `MPCR_CN_FIVE: used = 4'h5;
            `MPCR_CN_FOUR: used = 4'h4;
            default: used = 4'h3;
        endcase
    end
    // one comparator per cell
    genvar i;
    generate
        for (i = 0; i < CELLS; i = i + 1) begin : g_cell
            assign cell_enable[i] = (i < used);
        end
    endgenerate
endmodule
`default_nettype wire

// ---- mpcr_defines.vh ----
// constants for the protected monitor configuration register bank
`ifndef MPCR_DEFINES_VH
`define MPCR_DEFINES_VH
// ==========================================
// register offsets
`define MPCR_ADDR_FEATURE 8'h40
`define MPCR_ADDR_IO 8'h41
`define MPCR_ADDR_OVLIM 8'h42
`define MPCR_ADDR_UNLOCK 8'h3a
`define MPCR_PROT_LO 8'h40
`define MPCR_PROT_HI 8'h4f
`define MPCR_UNLOCK_CODE 8'h35
`define MPCR_ZERO8 8'h00
// ==========================================
// field positions
`define MPCR_F_REF 5
`define MPCR_F_SRC 4
`define MPCR_F_CN_HI 3
`define MPCR_F_CN_LO 2
`define MPCR_F_PINMASK 7
`define MPCR_F_CRCDIS 0
`define MPCR_F_OVDIS 7
`define MPCR_F_OV_HI 5
`define MPCR_F_OV_LO 0
// ==========================================
// writable masks and reset values
`define MPCR_MASK_FEATURE 8'h3c
`define MPCR_MASK_IO 8'h81
`define MPCR_MASK_OVLIM 8'hbf
`define MPCR_RST_FEATURE 8'h00
`define MPCR_RST_IO 8'h00
`define MPCR_RST_OVLIM 8'h00
// ==========================================
// threshold scale, millivolts
`define MPCR_OV_BASE_MV 14'h07d0
`define MPCR_OV_STEP_MV 14'h0032
`define MPCR_OV_MAX_CODE 6'h3c
// ==========================================
// cell-count codes
`define MPCR_CN_SIX 2'h0
`define MPCR_CN_FIVE 2'h1
`define MPCR_CN_FOUR 2'h2
`define MPCR_CN_THREE 2'h3
`endif

// ---- mpcr_host.sv ----
// host-side model driving register accesses and packet crc events
`default_nettype none
module mpcr_host (
    // clock
    input wire logic clk,
    // register access
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wr_data,
    // packet events
    output logic cs_release,
    output logic packet_crc_bad,
    output logic crc_flag_clear
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {wr_en, rd_en, addr, wr_data} = '0;
    initial {cs_release, packet_crc_bad, crc_flag_clear} = '0;
    // one byte write, strobe left high for back to back use
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_en <= 1'b1;
        rd_en <= 1'b0;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
    endtask
    // unlock then one protected write
    task automatic pwr(input logic [7:0] a, input logic [7:0] d);
        wr(8'h3a, 8'h35);
        wr(a, d);
        idle();
    endtask
    // one byte read, strobe dropped by idle after one cycle
    task automatic rd(input logic [7:0] a);
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        addr <= a;
        @(posedge clk);
        idle();
    endtask
    // chip select release with crc verdict, or a flag clear
    task automatic crc(input logic bad, input logic clr);
        cs_release <= ~clr;
        packet_crc_bad <= bad;
        crc_flag_clear <= clr;
        @(posedge clk);
        idle();
    endtask
    // release, stale lines scrambled
    task automatic idle();
        {wr_en, rd_en, cs_release, crc_flag_clear, packet_crc_bad} <= '0;
        addr <= ~addr;
        wr_data <= ~wr_data;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ---- mpcr_regs.v ----
// protected configuration register bank of a cell monitor
//
// Operation
// - bit 5 selects bandgap or 5 V reference
// - bit 4 selects external inputs or stack top
// - result scale follows selected source
// - bits 3:2 code six to three cells
// - pin mask clear: crc error sets flag, pin
// - pin mask set: crc error sets flag only
// - check disable clear: crc byte expected, appended
// - crc judged at chip select release
// - check disable set: no crc byte
// - bit 7 disables overvoltage detection
// - threshold 2 V plus 50 mV per code
// - protected writes need unlock code 0x35
// - unlock clears after any successful write except one to the unlock register
`include "mpcr_defines.vh"
`default_nettype none
module mpcr_regs #(
    parameter CELLS = 6
) (
    // clock, reset, enable
    input wire clk,
    input wire rst,
    input wire ce,
    // register access from the packet engine
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] addr,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    output reg wr_done,
    // packet crc events
    input wire cs_release,
    input wire packet_crc_bad,
    input wire crc_flag_clear,
    // comparator inputs, cell 1 in bit 0
    input wire [CELLS-1:0] ov_raw,
    input wire [CELLS-1:0] uv_raw,
    // converter steering
    output reg aux_input_reference_select,
    output reg aux_input_source_select,
    output reg aux_result_scale_stack,
    // packet format
    output reg packet_check_disable,
    output reg crc_byte_expected,
    // fault reporting
    output reg crc_fault_flag,
    output reg fault_pin,
    output reg [CELLS-1:0] ov_fault,
    output reg [CELLS-1:0] uv_fault,
    // threshold
    output reg [13:0] ov_threshold_mv
);
    // ==========================================
    // storage
    reg [7:0] feature_setup; // source, reference, cell count
    reg [7:0] io_options; // pin mask, check disable
    reg [7:0] overvoltage_limit; // disable and threshold code
    reg [7:0] protected_write_unlock; // unlock code holder
    wire [CELLS-1:0] cell_enable; // cells in use
    wire [1:0] series_cell_count; // count code field
    wire [5:0] overvoltage_threshold_code; // raw code
    reg [5:0] code_sat; // saturated code
    wire in_prot; // address in protected range
    wire unlocked; // unlock code present
    wire write_ok; // write that lands
    wire crc_event; // crc error at release
    reg next_crc_fault_flag; // flag value for the next edge

    assign series_cell_count =
        feature_setup[`MPCR_F_CN_HI:`MPCR_F_CN_LO];
    assign overvoltage_threshold_code =
        overvoltage_limit[`MPCR_F_OV_HI:`MPCR_F_OV_LO];
    assign in_prot = (addr >= `MPCR_PROT_LO) && (addr <= `MPCR_PROT_HI);
    assign unlocked = (protected_write_unlock == `MPCR_UNLOCK_CODE);
    // protected range refuses writes while locked
    assign write_ok = wr_en && (!in_prot || unlocked);
    // error only counts when judged at release
    assign crc_event = cs_release && packet_crc_bad &&
        !io_options[`MPCR_F_CRCDIS];

    // cell count decode
    mpcr_cell_mask #(
        .CELLS(CELLS)
    ) u_mask (
        .cell_code(series_cell_count),
        .cell_enable(cell_enable)
    );

    // ==========================================
    // threshold saturation
    always @* begin
        if (overvoltage_threshold_code > `MPCR_OV_MAX_CODE) begin
            code_sat = `MPCR_OV_MAX_CODE;
        end else begin
            code_sat = overvoltage_threshold_code;
        end
    end

    // ==========================================
    // register writes and unlock handling
    always @(posedge clk) begin
        if (rst) begin
            feature_setup <= `MPCR_RST_FEATURE;
            io_options <= `MPCR_RST_IO;
            overvoltage_limit <= `MPCR_RST_OVLIM;
            protected_write_unlock <= `MPCR_ZERO8;
            wr_done <= 1'b0;
        end else if (ce) begin
            wr_done <= write_ok;
            if (write_ok) begin
                // any landed write closes the unlock, except a write to the unlock register, which stores its data
                protected_write_unlock <= `MPCR_ZERO8;
                // reserved bits are stored as zero
                if (addr == `MPCR_ADDR_FEATURE) begin
                    feature_setup <= wr_data & `MPCR_MASK_FEATURE;
                end else if (addr == `MPCR_ADDR_IO) begin
                    io_options <= wr_data & `MPCR_MASK_IO;
                end else if (addr == `MPCR_ADDR_OVLIM) begin
                    overvoltage_limit <= wr_data & `MPCR_MASK_OVLIM;
                end else if (addr == `MPCR_ADDR_UNLOCK) begin
                    protected_write_unlock <= wr_data;
                end
            end
        end
    end

    // ==========================================
    // read mux, unlock reads as zero
    always @(posedge clk) begin
        if (rst) begin
            rd_data <= `MPCR_ZERO8;
        end else if (ce && rd_en) begin
            if (addr == `MPCR_ADDR_FEATURE) begin
                rd_data <= feature_setup;
            end else if (addr == `MPCR_ADDR_IO) begin
                rd_data <= io_options;
            end else if (addr == `MPCR_ADDR_OVLIM) begin
                rd_data <= overvoltage_limit;
            end else begin
                // unlock, reserved and unmapped addresses
                rd_data <= `MPCR_ZERO8;
            end
        end
    end

    // ==========================================
    // crc fault flag and pin
    // next flag value, a fresh error beats a clear in the same cycle
    always @* begin
        if (crc_event) begin
            next_crc_fault_flag = 1'b1;
        end else if (crc_flag_clear) begin
            next_crc_fault_flag = 1'b0; // host clear
        end else begin
            next_crc_fault_flag = crc_fault_flag; // sticky
        end
    end

    // flag and pin registers move together
    always @(posedge clk) begin
        if (rst) begin
            crc_fault_flag <= 1'b0;
            fault_pin <= 1'b0;
        end else if (ce) begin
            crc_fault_flag <= next_crc_fault_flag;
            // mask bit keeps the pin quiet, the flag still records
            fault_pin <= next_crc_fault_flag &&
                !io_options[`MPCR_F_PINMASK];
        end
    end

    // ==========================================
    // converter steering and packet format
    always @(posedge clk) begin
        if (rst) begin
            aux_input_reference_select <= 1'b0; // bandgap
            aux_input_source_select <= 1'b0; // external inputs
            aux_result_scale_stack <= 1'b0; // external scale
            packet_check_disable <= 1'b0; // crc in use
            crc_byte_expected <= 1'b1; // crc byte present
        end else if (ce) begin
            aux_input_reference_select <= feature_setup[`MPCR_F_REF];
            aux_input_source_select <= feature_setup[`MPCR_F_SRC];
            // result scale tracks whichever source is muxed in
            aux_result_scale_stack <= feature_setup[`MPCR_F_SRC];
            packet_check_disable <= io_options[`MPCR_F_CRCDIS];
            crc_byte_expected <= !io_options[`MPCR_F_CRCDIS];
        end
    end

    // ==========================================
    // comparator masking
    always @(posedge clk) begin
        if (rst) begin
            ov_fault <= {CELLS{1'b0}};
            uv_fault <= {CELLS{1'b0}};
        end else if (ce) begin
            // detection off when disable bit set
            ov_fault <= overvoltage_limit[`MPCR_F_OVDIS] ?
                {CELLS{1'b0}} : (ov_raw & cell_enable);
            // cells above the configured count never report
            uv_fault <= uv_raw & cell_enable;
        end
    end

    // ==========================================
    // threshold in millivolts
    always @(posedge clk) begin
        if (rst) begin
            ov_threshold_mv <= `MPCR_OV_BASE_MV; // code zero
        end else if (ce) begin
            // linear scale, base plus one step per code
            ov_threshold_mv <= `MPCR_OV_BASE_MV +
                code_sat * `MPCR_OV_STEP_MV;
        end
    end
endmodule
`default_nettype wire

// ---- mpcr_regs_props.sv ----
// assertions for the protected config register bank
`default_nettype none
module mpcr_regs_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register access
    input wire logic ce,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic wr_done,
    // crc events and outputs
    input wire logic cs_release,
    input wire logic packet_crc_bad,
    input wire logic crc_flag_clear,
    input wire logic packet_check_disable,
    input wire logic crc_byte_expected,
    input wire logic crc_fault_flag,
    input wire logic fault_pin,
    input wire logic [13:0] ov_threshold_mv
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // access steps
    sequence s_unlock;
        ce && wr_en && addr == 8'h3a && wr_data == 8'h35;
    endsequence
    sequence s_prot;
        ce && wr_en && addr == 8'h42;
    endsequence
    sequence s_prot_any;
        ce && wr_en && addr >= 8'h40 && addr <= 8'h4f;
    endsequence
    // ==========================================
    // properties
    unlock_write_a: assert property (
        s_unlock ##1 s_prot_any |=> wr_done)
        else $error("unlocked write not taken");
    relock_drop_a: assert property (
        s_prot_any ##1 s_prot_any |=> !wr_done)
        else $error("second write without unlock taken");
    thr_code_a: assert property (s_prot ##1 (ce && wr_done) |=>
        ov_threshold_mv == 14'd2000 + 14'd50 * (($past(wr_data, 2) & 8'h3f)
        > 8'h3c ? 14'd60 : {8'h00, $past(wr_data[5:0], 2)}))
        else $error("threshold does not follow code");
    unlock_read_a: assert property (ce && rd_en && addr == 8'h3a |=>
        rd_data == 8'h00) else $error("unlock register reads nonzero");
    // the disable output lags the option by one cycle, so a flag is
    // only owed when the next disable value still shows checking on
    crc_set_a: assert property (ce && cs_release && packet_crc_bad
        && !packet_check_disable |=> crc_fault_flag || packet_check_disable)
        else $error("crc error did not set flag");
    flag_hold_a: assert property ($fell(crc_fault_flag) |->
        $past(crc_flag_clear) || $past(rst)) else $error("flag lost");
    pin_flag_a: assert property (fault_pin |->
        crc_fault_flag || $past(crc_fault_flag)) else $error("stray pin");
    format_a: assert property (
        crc_byte_expected != packet_check_disable)
        else $error("crc format outputs disagree");
endmodule
bind mpcr_regs mpcr_regs_props chk (.clk, .rst, .ce, .wr_en, .rd_en,
    .addr, .wr_data, .rd_data, .wr_done, .cs_release, .packet_crc_bad,
    .crc_flag_clear, .packet_check_disable, .crc_byte_expected,
    .crc_fault_flag, .fault_pin, .ov_threshold_mv);
`default_nettype wire

// ---- tb_monitor_protection_config_regs.sv ----
// self-checking bench for the protected config register bank
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
    n_fail++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_monitor_protection_config_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, ce, wr_en, rd_en, wr_done, cs_release, packet_crc_bad;
    logic crc_flag_clear, aux_input_reference_select, fault_pin;
    logic aux_input_source_select, aux_result_scale_stack, crc_fault_flag;
    logic packet_check_disable, crc_byte_expected;
    logic [5:0] ov_raw, uv_raw, ov_fault, uv_fault;
    logic [7:0] addr, wr_data, rd_data, k;
    logic [13:0] ov_threshold_mv;
    int n_fail = 0, n_compared = 0, cyc = 0, n_done = 0;
    mpcr_host h (.clk, .wr_en, .rd_en, .addr, .wr_data, .cs_release,
        .packet_crc_bad, .crc_flag_clear);
    mpcr_regs dut (.clk, .rst, .ce, .wr_en, .rd_en, .addr, .wr_data,
        .rd_data, .wr_done, .cs_release, .packet_crc_bad, .crc_flag_clear,
        .ov_raw, .uv_raw, .aux_input_reference_select, .fault_pin,
        .aux_input_source_select, .aux_result_scale_stack, .ov_fault,
        .packet_check_disable, .crc_byte_expected, .crc_fault_flag,
        .uv_fault, .ov_threshold_mv);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            wrap_up();
        end
    end
    // count landed writes, sampled before the edge updates them
    always @(posedge clk) begin
        if (wr_done) begin
            n_done <= n_done + 1;
        end
    end
    // reset values, cell count and source codes
    task t_cells;
        @(negedge clk);
        `CHK("crcexp", 1'b1, crc_byte_expected)
        `CHK("thr0", 14'd2000, ov_threshold_mv)
        `CHK("flag0", 1'b0, crc_fault_flag)
        @(posedge clk);
        uv_raw <= 6'h35;
        for (int c = 0; c < 4; c++) begin
            h.pwr(8'h40, {2'b11, c[0], c[1], c[1:0], 2'b11});
            h.rd(8'h40);
            @(negedge clk);
            `CHK("ref", c[0], aux_input_reference_select)
            `CHK("src", c[1], aux_input_source_select)
            `CHK("scale", c[1], aux_result_scale_stack)
            `CHK("ovmask", 6'h3f >> c, ov_fault)
            `CHK("uvmask", 6'h35 & (6'h3f >> c), uv_fault)
            `CHK("feat", {2'b00, c[0], c[1], c[1:0], 2'b00}, rd_data)
            @(posedge clk);
        end
    endtask
    // threshold codes, saturation and disable
    task t_ov;
        logic [13:0] exp_mv;
        for (int i = 0; i < 4; i++) begin
            k = i[1] ? (i[0] ? 8'h81 : 8'h3f) : (i[0] ? 8'h3c : 8'h00);
            h.pwr(8'h42, k);
            @(negedge clk);
            exp_mv = 14'd2000 + 14'd50 *
                (k[5:0] > 6'h3c ? 14'd60 : {8'h00, k[5:0]});
            `CHK("thr", exp_mv, ov_threshold_mv)
            `CHK("ovdis", k[7] ? 6'h00 : 6'h07, ov_fault)
            @(posedge clk);
        end
    endtask
    // locked, relocked, unlock and unmapped reads
    task t_lock;
        int base;
        base = n_done;
        h.wr(8'h42, 8'h10);
        h.wr(8'h3a, 8'h35);
        h.wr(8'h41, 8'h80);
        h.wr(8'h41, 8'h01);
        h.idle();
        for (int i = 0; i < 4; i++) begin
            h.rd(i[1] ? (i[0] ? 8'h50 : 8'h3a) : (i[0] ? 8'h41 : 8'h42));
            @(negedge clk);
            k = i[1] ? 8'h00 : (i[0] ? 8'h80 : 8'h81);
            `CHK("lock", k, rd_data)
            @(posedge clk);
        end
        // refused, unlock, landed, refused again
        `CHK("done", 2, n_done - base)
    endtask
    // crc error with no option, pin mask only, check disable only, then clear
    task t_crc;
        for (int i = 0; i < 3; i++) begin
            k = i[1] ? 8'h01 : (i[0] ? 8'h80 : 8'h00);
            h.pwr(8'h41, k);
            h.crc(1'b1, 1'b0);
            @(negedge clk);
            `CHK("flag", ~k[0], crc_fault_flag)
            `CHK("pin", ~k[0] & ~k[7], fault_pin)
            `CHK("fmt", ~k[0], crc_byte_expected)
            `CHK("dis", k[0], packet_check_disable)
            @(posedge clk);
            h.crc(1'b0, 1'b1);
            @(negedge clk);
            `CHK("clear", 1'b0, crc_fault_flag)
            `CHK("pinclr", 1'b0, fault_pin)
            @(posedge clk);
        end
    endtask
    task wrap_up;
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        ov_raw = 6'h3f;
        uv_raw = 6'h3f;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_cells();
        t_ov();
        t_lock();
        t_crc();
        wrap_up();
    end
endmodule
`default_nettype wire
